// >>> hdl/capture_compare_unit.sv
/*
 * capture/compare array with two base timers and an avalon-mm slave.
 * assumes port pins and the external count input are asynchronous,
 * and the external overflow pulse comes from logic on ref_clk.
 */
// Added by the designer: the register addresses and the Avalon-MM register port.
// Functional notes
// - sixteen channels, resolution one clock, or eight clocks in staggered operation.
// - two independent 16-bit base timers, each with its own reload register.
// - each timer counts prescaled clock ticks or overflow pulses of an external timer.
// - the first timer can also count rising edges of an external count input.
// - sixteen registers, each assignable to either timer and to compare; the ten with a pin also to capture.
// - ten registers own a pin, capture input or compare output by mode.
// - compare mode 0 only requests an interrupt, any number of times per period.
// - compare mode 1 toggles the pin on every match.
// - compare mode 2 only requests an interrupt, at most once per timer period.
// - compare mode 3 sets the pin on a match, clears it on timer overflow, once a period.
// - double mode lets two registers toggle one shared pin on either match.
// - single-event option stops compare events after the first one.
// - capture latches the allocated timer on the pin event and requests an interrupt.
// - capture trigger is rising, falling or both edges.
// - every compare-mode register is compared with its timer and acts on equality.
`timescale 1ns/1ps
module capture_compare_unit
   import cc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [cc_pkg::AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [cc_pkg::DW-1:0] avs_writedata,
   output logic [cc_pkg::DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   // channel pins
   input wire logic [cc_pkg::PIN_N-1:0] cc_pin_in,
   output logic [cc_pkg::PIN_N-1:0] cc_pin_out,
   output logic [cc_pkg::PIN_N-1:0] cc_pin_oe,
   // count sources
   input wire logic ext_ovf_pulse,
   input wire logic ext_count_in,
   // interrupt
   output logic irq
);
   import cc_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic ack_r;
   logic wr_en;
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] rd_nxt;
   logic [TCTL_W-1:0] tctl_r;
   logic [CH_N-1:0] istat_r;
   logic [CH_N-1:0] imask_r;
   logic [CFG_W-1:0] cfg_r [CH_N];
   logic [TW-1:0] val_r [CH_N];
   logic [CH_N-1:0] done_r;
   logic [CH_N-1:0] fired_r;
   logic [PIN_N-1:0] pin_s1_r;
   logic [PIN_N-1:0] pin_s2_r;
   logic [PIN_N-1:0] pin_s3_r;
   logic [PIN_N-1:0] pin_r;
   logic [PIN_N-1:0] oe_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic ext_rise;
   logic [PIN_N-1:0] rise;
   logic [PIN_N-1:0] fall;
   logic [TW-1:0] tcnt [TMR_N];
   logic [TW-1:0] trel [TMR_N];
   logic [TMR_N-1:0] tstep;
   logic [TMR_N-1:0] tovf;
   logic [CH_N-1:0] cmp_evt;
   logic [CH_N-1:0] cap_evt;
   logic [CH_N-1:0] ch_ovf;
   logic [CH_N-1:0] cfg_wr;
   logic [CH_N-1:0] val_wr;
   logic [TW-1:0] ch_tv [CH_N];
   logic [PIN_N-1:0] pin_tog;
   logic [PIN_N-1:0] pin_set;
   logic [PIN_N-1:0] pin_clr;
   logic [PIN_N-1:0] oe_nxt;

   // ****************************************************************
   // avalon slave: one wait cycle per access
   // ****************************************************************
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_en = avs_write && ack_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read || avs_write) && !ack_r;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rdata_r <= '0;
      else if (avs_read && !ack_r)
         rdata_r <= rd_nxt;
   end

   assign avs_readdata = rdata_r;

   always_comb begin
      rd_nxt = '0;
      if (avs_address == OFS_TCTL)
         rd_nxt = DW'(tctl_r);
      else if (avs_address == OFS_ISTAT)
         rd_nxt = DW'(istat_r);
      else if (avs_address == OFS_IMASK)
         rd_nxt = DW'(imask_r);
      else if (avs_address == OFS_PINS)
         rd_nxt = DW'(pin_r);
      for (int t = 0; t < TMR_N; t++) begin
         if (avs_address == OFS_TA_CNT + AW'(t) * TMR_STRIDE)
            rd_nxt = DW'(tcnt[t]);
         if (avs_address == OFS_TA_REL + AW'(t) * TMR_STRIDE)
            rd_nxt = DW'(trel[t]);
      end
      for (int i = 0; i < CH_N; i++) begin
         if (avs_address == OFS_CFG + AW'(i))
            rd_nxt = DW'({done_r[i], cfg_r[i]});
         if (avs_address == OFS_VAL + AW'(i))
            rd_nxt = DW'(val_r[i]);
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         tctl_r <= '0;
      else if (wr_en && avs_address == OFS_TCTL)
         tctl_r <= avs_writedata[TCTL_W-1:0];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         imask_r <= '0;
      else if (wr_en && avs_address == OFS_IMASK)
         imask_r <= avs_writedata[CH_N-1:0];
   end

   // ****************************************************************
   // interrupt status: set wins over write-one-to-clear
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         istat_r <= '0;
      else if (wr_en && avs_address == OFS_ISTAT)
         istat_r <= (istat_r & ~avs_writedata[CH_N-1:0]) | cmp_evt | cap_evt;
      else
         istat_r <= istat_r | cmp_evt | cap_evt;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(istat_r & imask_r);
   end

   // ****************************************************************
   // input synchronisers and edge detection
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= cc_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         ext_s1_r <= ext_count_in;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   assign rise = pin_s2_r & ~pin_s3_r;
   assign fall = ~pin_s2_r & pin_s3_r;
   assign ext_rise = ext_s2_r && !ext_s3_r;

   // ****************************************************************
   // base timers
   // ****************************************************************
   base_timer_if tif [TMR_N] ();

   generate
      for (genvar t = 0; t < TMR_N; t++) begin : g_tmr
         assign tif[t].run = tctl_r[t * TCTL_STRIDE + TCTL_RUN];
         assign tif[t].sel = tctl_r[t * TCTL_STRIDE + TCTL_SEL_LSB +: 3];
         assign tif[t].stag = tctl_r[TCTL_STAG];
         assign tif[t].wdata = avs_writedata[TW-1:0];
         assign tif[t].ld_cnt = wr_en &&
            (avs_address == OFS_TA_CNT + AW'(t) * TMR_STRIDE);
         assign tif[t].ld_rel = wr_en &&
            (avs_address == OFS_TA_REL + AW'(t) * TMR_STRIDE);
         assign tcnt[t] = tif[t].cnt;
         assign trel[t] = tif[t].rel;
         assign tstep[t] = tif[t].step;
         assign tovf[t] = tif[t].ovf;
         base_timer u_tmr (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .ext_ovf(ext_ovf_pulse),
            .ext_cnt((t == 0) ? ext_rise : 1'b0),
            .tif(tif[t])
         );
      end
   endgenerate

   // ****************************************************************
   // channel events
   // ****************************************************************
   always_comb begin
      for (int i = 0; i < CH_N; i++) begin
         ch_tv[i] = tcnt[cfg_r[i][CFG_TSEL]];
         ch_ovf[i] = tovf[cfg_r[i][CFG_TSEL]];
         cfg_wr[i] = wr_en && avs_address == OFS_CFG + AW'(i);
         val_wr[i] = wr_en && avs_address == OFS_VAL + AW'(i);
         cmp_evt[i] = is_cmp(cfg_r[i][CFG_MODE_LSB +: 3]) &&
            tstep[cfg_r[i][CFG_TSEL]] && ch_tv[i] == val_r[i] &&
            !(cfg_r[i][CFG_SINGLE] && done_r[i]) &&
            !fired_r[i];
         cap_evt[i] = 1'b0;
         if (i < PIN_N)
            cap_evt[i] = cfg_r[i][CFG_MODE_LSB +: 3] == 3'(MODE_CAPTURE) &&
               ((cfg_r[i][CFG_RISE] && rise[i % PIN_N]) ||
                (cfg_r[i][CFG_FALL] && fall[i % PIN_N]));
      end
   end

   // ****************************************************************
   // channel registers
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CH_N; i++)
            cfg_r[i] <= '0;
      end else begin
         for (int i = 0; i < CH_N; i++)
            if (cfg_wr[i])
               cfg_r[i] <= avs_writedata[CFG_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CH_N; i++)
            val_r[i] <= '0;
      end else begin
         for (int i = 0; i < CH_N; i++)
            if (cap_evt[i])
               val_r[i] <= ch_tv[i];
            else if (val_wr[i])
               val_r[i] <= avs_writedata[TW-1:0];
      end
   end

   // single-event lock, released by rewriting the channel configuration
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         done_r <= '0;
      else
         for (int i = 0; i < CH_N; i++)
            if (cmp_evt[i] && cfg_r[i][CFG_SINGLE])
               done_r[i] <= 1'b1;
            else if (cfg_wr[i])
               done_r[i] <= 1'b0;
   end

   // once-per-period lock for modes 2 and 3, released by timer overflow
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         fired_r <= '0;
      else
         for (int i = 0; i < CH_N; i++)
            if (cmp_evt[i] && (cfg_r[i][CFG_MODE_LSB +: 3] == 3'(MODE_CMP2) ||
                               cfg_r[i][CFG_MODE_LSB +: 3] == 3'(MODE_CMP3)))
               fired_r[i] <= 1'b1;
            else if (ch_ovf[i] || cfg_wr[i])
               fired_r[i] <= 1'b0;
   end

   // ****************************************************************
   // pin actions
   // ****************************************************************
   generate
      for (genvar p = 0; p < PIN_N; p++) begin : g_pin
         logic own_tog;
         logic mate_tog;
         logic mate_oe;
         assign own_tog = cmp_evt[p] &&
            (cfg_r[p][CFG_MODE_LSB +: 3] == 3'(MODE_CMP1) ||
             cfg_r[p][CFG_MODE_LSB +: 3] == 3'(MODE_DOUBLE));
         if (p + DBL_OFS < CH_N) begin : g_mate
            assign mate_tog = cmp_evt[p + DBL_OFS] &&
               cfg_r[p + DBL_OFS][CFG_MODE_LSB +: 3] == 3'(MODE_DOUBLE);
            assign mate_oe = cfg_r[p + DBL_OFS][CFG_MODE_LSB +: 3] == 3'(MODE_DOUBLE);
         end else begin : g_nomate
            assign mate_tog = 1'b0;
            assign mate_oe = 1'b0;
         end
         assign pin_tog[p] = own_tog || mate_tog;
         assign pin_set[p] = cmp_evt[p] &&
            cfg_r[p][CFG_MODE_LSB +: 3] == 3'(MODE_CMP3);
         assign pin_clr[p] = ch_ovf[p] &&
            cfg_r[p][CFG_MODE_LSB +: 3] == 3'(MODE_CMP3);
         assign oe_nxt[p] = is_pin_mode(cfg_r[p][CFG_MODE_LSB +: 3]) || mate_oe;
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         pin_r <= '0;
      else
         for (int p = 0; p < PIN_N; p++)
            if (pin_set[p])
               pin_r[p] <= 1'b1;
            else if (pin_clr[p])
               pin_r[p] <= 1'b0;
            else if (pin_tog[p])
               pin_r[p] <= !pin_r[p];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         oe_r <= '0;
      else
         oe_r <= oe_nxt;
   end

   assign cc_pin_out = pin_r;
   assign cc_pin_oe = oe_r;

endmodule : capture_compare_unit

// >>> include/cc_pkg.sv
/*
 * constants, field layout and mode codes of the capture/compare unit.
 * assumes a 32-bit avalon register bus with word addressing.
 */
package cc_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int CH_N = 16;
   localparam int PIN_N = 10;
   localparam int TW = 16;
   localparam int AW = 6;
   localparam int DW = 32;
   localparam int PRE_W = 8;
   localparam int TMR_N = 2;
   localparam int DBL_OFS = 8;
   localparam int STAG_SHIFT = 3;

   // ****************************************************************
   // register indices (word address)
   // ****************************************************************
   localparam logic [AW-1:0] OFS_TCTL = 6'h00;
   localparam logic [AW-1:0] OFS_TA_CNT = 6'h01;
   localparam logic [AW-1:0] OFS_TA_REL = 6'h02;
   localparam logic [AW-1:0] TMR_STRIDE = 6'h02;
   localparam logic [AW-1:0] OFS_ISTAT = 6'h05;
   localparam logic [AW-1:0] OFS_IMASK = 6'h06;
   localparam logic [AW-1:0] OFS_PINS = 6'h07;
   localparam logic [AW-1:0] OFS_CFG = 6'h10;
   localparam logic [AW-1:0] OFS_VAL = 6'h20;

   // ****************************************************************
   // fields
   // ****************************************************************
   localparam int TCTL_SEL_LSB = 0;
   localparam int TCTL_RUN = 3;
   localparam int TCTL_STRIDE = 4;
   localparam int TCTL_STAG = 8;
   localparam int TCTL_W = 9;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_TSEL = 3;
   localparam int CFG_RISE = 4;
   localparam int CFG_FALL = 5;
   localparam int CFG_SINGLE = 6;
   localparam int CFG_DONE = 7;
   localparam int CFG_W = 7;
   localparam logic [2:0] CSEL_EXT_OVF = 3'h6;
   localparam logic [2:0] CSEL_EXT_CNT = 3'h7;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_CAPTURE, MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3, MODE_DOUBLE
   } cc_mode_t;

   function automatic logic is_cmp(input logic [2:0] m);
      is_cmp = (m >= 3'(MODE_CMP0)) && (m <= 3'(MODE_DOUBLE));
   endfunction : is_cmp

   function automatic logic is_pin_mode(input logic [2:0] m);
      is_pin_mode = (m == 3'(MODE_CMP1)) || (m == 3'(MODE_CMP3)) || (m == 3'(MODE_DOUBLE));
   endfunction : is_pin_mode

endpackage : cc_pkg

// >>> include/base_timer_if.sv
/*
 * bundle between the register block and one base timer.
 * assumes cc_pkg is compiled first.
 */
`timescale 1ns/1ps
interface base_timer_if;
   logic run;
   logic [2:0] sel;
   logic stag;
   logic ld_cnt;
   logic ld_rel;
   logic [cc_pkg::TW-1:0] wdata;
   logic [cc_pkg::TW-1:0] cnt;
   logic [cc_pkg::TW-1:0] rel;
   logic step;
   logic ovf;
   modport timer (input run, sel, stag, ld_cnt, ld_rel, wdata, output cnt, rel, step, ovf);
   modport user (output run, sel, stag, ld_cnt, ld_rel, wdata, input cnt, rel, step, ovf);
endinterface : base_timer_if

// >>> hdl/base_timer.sv
/*
 * one reloadable 16-bit up counting base timer with prescaler.
 * assumes ext_ovf and ext_cnt are single-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module base_timer
   import cc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // count sources
   input wire logic ext_ovf,
   input wire logic ext_cnt,
   // control and state
   base_timer_if.timer tif
);
   import cc_pkg::*;

   logic [PRE_W-1:0] pre_r;
   logic [PRE_W:0] one_sh;
   logic [PRE_W-1:0] div_m1;
   logic [3:0] shift;
   logic tick;
   logic [TW-1:0] cnt_r;
   logic [TW-1:0] rel_r;
   logic step_r;
   logic ovf_r;

   // ****************************************************************
   // prescaler
   // ****************************************************************
   always_comb begin
      shift = {1'b0, tif.sel} + (tif.stag ? 4'(STAG_SHIFT) : 4'h0);
      one_sh = (PRE_W+1)'(1) << shift;
      div_m1 = PRE_W'(one_sh - (PRE_W+1)'(1));
      if (!tif.run)
         tick = 1'b0;
      else if (tif.sel == CSEL_EXT_OVF)
         tick = ext_ovf;
      else if (tif.sel == CSEL_EXT_CNT)
         tick = ext_cnt;
      else
         tick = (pre_r >= div_m1);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         pre_r <= '0;
      else if (!tif.run || pre_r >= div_m1)
         pre_r <= '0;
      else
         pre_r <= pre_r + PRE_W'(1);
   end

   // ****************************************************************
   // counter with reload
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rel_r <= '0;
      else if (tif.ld_rel)
         rel_r <= tif.wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         step_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         step_r <= tick && !tif.ld_cnt;
         ovf_r <= tick && !tif.ld_cnt && (cnt_r == '1);
         if (tif.ld_cnt)
            cnt_r <= tif.wdata;
         else if (tick && cnt_r == '1)
            cnt_r <= rel_r;
         else if (tick)
            cnt_r <= cnt_r + TW'(1);
      end
   end

   assign tif.cnt = cnt_r;
   assign tif.rel = rel_r;
   assign tif.step = step_r;
   assign tif.ovf = ovf_r;

endmodule : base_timer

// >>> verif/cc_pin_model.sv
/* outside world of the pins and count inputs.
   assumes changes just after a rising edge. */
`timescale 1ns/1ps
module cc_pin_model
   import cc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // pins from the unit
   input wire logic [cc_pkg::PIN_N-1:0] pin_out,
   input wire logic [cc_pkg::PIN_N-1:0] pin_oe,
   // levels seen by the unit
   output logic [cc_pkg::PIN_N-1:0] pin_in,
   output logic ext_cnt,
   output logic ext_ovf
);
   logic [PIN_N-1:0] drv_r = 10'h0;
   initial begin
      ext_cnt = 1'h0;
      ext_ovf = 1'h0;
   end
   // driven bits show the unit's level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_r);
   // **********
   // stimulus tasks
   // **********
   task automatic set_pin(input int ch, input logic lvl);
      @(posedge ref_clk);
      drv_r[ch] <= lvl;
   endtask : set_pin
   task automatic pulses(input logic ovf, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         if (ovf)
            ext_ovf <= 1'h1;
         else
            ext_cnt <= 1'h1;
         @(posedge ref_clk);
         ext_ovf <= 1'h0;
         ext_cnt <= 1'h0;
         repeat (2) @(posedge ref_clk);
      end
   endtask : pulses
endmodule : cc_pin_model

// >>> verif/capture_compare_unit_chk.sv
/* port checks of the capture/compare unit.
   assumes a bind into the unit. */
`timescale 1ns/1ps
module capture_compare_unit_chk
   import cc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [cc_pkg::AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [cc_pkg::DW-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // channel pins
   input wire logic [cc_pkg::PIN_N-1:0] cc_pin_out,
   input wire logic [cc_pkg::PIN_N-1:0] cc_pin_oe
);
   wire logic rd_ok = avs_read && !avs_waitrequest;
   wire logic wr_ok = avs_write && !avs_waitrequest;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // **********
   // bus handshake and read data
   // **********
   a_one_wait_state:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("second wait state");
   a_idle_no_wait:
      assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("idle wait");
   a_new_req_waits:
      assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait state");
   a_data_stands:
      assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved");
   a_unmapped_zero:
      assert property (rd_ok && (avs_address inside {[6'h08:6'h0f], [6'h30:6'h3f]})
         |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_value_width:
      assert property (rd_ok && avs_address[5:4] == 2'h2 |-> avs_readdata[31:16] == 16'h0)
      else $error("value upper bits");
   a_config_width:
      assert property (rd_ok && avs_address[5:4] == 2'h1 |-> avs_readdata[31:8] == 24'h0)
      else $error("config upper bits");
   // **********
   // pins
   // **********
   a_pin_readback:
      assert property (rd_ok && avs_address == OFS_PINS
         |-> avs_readdata == {22'h0, $past(cc_pin_out)})
      else $error("pin readback wrong");
   a_oe_after_write:
      assert property ($changed(cc_pin_oe) |-> $past(wr_ok) || $past(wr_ok, 2))
      else $error("pin enable moved unasked");
endmodule : capture_compare_unit_chk

bind capture_compare_unit capture_compare_unit_chk u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe)
);

// >>> verif/capture_compare_unit_tb_top.sv
/* self-checking bench of the capture/compare unit.
   assumes all other files are compiled first. */
`timescale 1ns/1ps
module capture_compare_unit_tb_top;
   import cc_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [AW-1:0] avs_address = 6'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [DW-1:0] avs_writedata = 32'h0;
   logic [DW-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [PIN_N-1:0] cc_pin_in;
   logic [PIN_N-1:0] cc_pin_out;
   logic [PIN_N-1:0] cc_pin_oe;
   logic ext_ovf_pulse;
   logic ext_count_in;
   logic irq;
   logic [DW-1:0] rv;
   int fails = 0;
   int n_compared = 0;
   int tg;
   capture_compare_unit dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
      .cc_pin_oe(cc_pin_oe), .ext_ovf_pulse(ext_ovf_pulse), .ext_count_in(ext_count_in),
      .irq(irq)
   );
   cc_pin_model pm (
      .ref_clk(ref_clk), .pin_out(cc_pin_out), .pin_oe(cc_pin_oe), .pin_in(cc_pin_in),
      .ext_cnt(ext_count_in), .ext_ovf(ext_ovf_pulse)
   );
   initial forever #5 ref_clk = ~ref_clk;
   // **********
   // shared tasks
   // **********
   task automatic chk(input string w, input logic [DW-1:0] e, input logic [DW-1:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge ref_clk);
         t++;
      end while (avs_waitrequest !== 1'h0);
      chk("bus edges", 32'h2, 32'(t));
      rv = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      bus(1'h1, a, d);
   endtask : wr
   task automatic rchk(input string w, input logic [AW-1:0] a, input logic [DW-1:0] e);
      bus(1'h0, a, 32'h0);
      chk(w, e, rv);
   endtask : rchk
   task automatic toggles(input int ch, input int n, output int c);
      logic p;
      c = 0;
      @(negedge ref_clk);
      p = cc_pin_out[ch];
      repeat (n) begin
         @(negedge ref_clk);
         if (cc_pin_out[ch] !== p) c++;
         p = cc_pin_out[ch];
      end
   endtask : toggles
   // **********
   // scenarios
   // **********
   task automatic t_regs();
      rchk("control reset", OFS_TCTL, 32'h0);
      rchk("pins reset", OFS_PINS, 32'h0);
      @(negedge ref_clk);
      chk("oe reset", 32'h0, 32'(cc_pin_oe));
      chk("irq reset", 32'h0, 32'(irq));
      wr(OFS_TA_REL, 32'h1234abcd);
      rchk("reload width", OFS_TA_REL, 32'habcd);
      wr(6'h08, 32'hffffffff);
      rchk("unmapped", 6'h08, 32'h0);
      wr(OFS_PINS, 32'h3ff);
      rchk("pins read only", OFS_PINS, 32'h0);
      $display("registers done");
   endtask : t_regs
   task automatic t_compare();
      wr(OFS_TA_REL, 32'hfff0);
      wr(OFS_TA_CNT, 32'hfff0);
      wr(OFS_VAL, 32'hfff4);
      wr(OFS_VAL + 6'h08, 32'hfffa);
      wr(OFS_CFG, 32'h03);
      wr(OFS_TCTL, 32'h08);
      toggles(0, 160, tg);
      chk("toggle count", 32'ha, 32'(tg));
      chk("toggle oe", 32'h1, 32'(cc_pin_oe[0]));
      wr(OFS_CFG + 6'h08, 32'h06);
      toggles(0, 160, tg);
      chk("double toggles", 32'h14, 32'(tg));
      wr(OFS_TCTL, 32'h09);
      toggles(0, 160, tg);
      chk("prescaled toggles", 32'ha, 32'(tg));
      wr(OFS_TCTL, 32'h108);
      toggles(0, 256, tg);
      chk("staggered toggles", 32'h4, 32'(tg));
      wr(OFS_TCTL, 32'h08);
      wr(OFS_CFG + 6'h08, 32'h0);
      wr(OFS_CFG, 32'h43);
      toggles(0, 160, tg);
      chk("single toggles", 32'h1, 32'(tg));
      rchk("single done", OFS_CFG, 32'hc3);
      wr(OFS_VAL + 6'h03, 32'hfff8);
      wr(OFS_CFG + 6'h03, 32'h05);
      toggles(3, 160, tg);
      chk("set and clear edges", 32'h14, 32'(tg));
      $display("compare done");
   endtask : t_compare
   task automatic t_irq();
      wr(OFS_TCTL, 32'h0);
      wr(OFS_ISTAT, 32'hffff);
      wr(OFS_TA_CNT + TMR_STRIDE, 32'h0100);
      wr(OFS_TA_REL + TMR_STRIDE, 32'h0);
      wr(OFS_VAL + 6'h01, 32'h0110);
      wr(OFS_VAL + 6'h02, 32'h0110);
      wr(OFS_CFG + 6'h01, 32'h0a);
      wr(OFS_CFG + 6'h02, 32'h0c);
      wr(OFS_IMASK, 32'h2);
      wr(OFS_TCTL, 32'h80);
      repeat (40) @(negedge ref_clk);
      rchk("irq flags", OFS_ISTAT, 32'h6);
      wr(OFS_ISTAT, 32'h6);
      wr(OFS_TA_CNT + TMR_STRIDE, 32'h0100);
      repeat (40) @(negedge ref_clk);
      rchk("once per period", OFS_ISTAT, 32'h2);
      @(negedge ref_clk);
      chk("irq level", 32'h1, 32'(irq));
      chk("no pin action", 32'h0, 32'(cc_pin_oe[2:1]));
      wr(OFS_IMASK, 32'h0);
      repeat (2) @(negedge ref_clk);
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFS_ISTAT, 32'h2);
      wr(OFS_IMASK, 32'h2);
      repeat (2) @(negedge ref_clk);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("interrupt done");
   endtask : t_irq
   task automatic t_capture();
      logic [TW-1:0] c;
      logic [TW-1:0] last;
      logic [5:0] hit;
      hit = 6'h39;
      last = 16'h0;
      wr(OFS_TCTL, 32'h0);
      for (int i = 0; i < 6; i++) begin
         c = 16'h1111 * 16'(i + 1);
         wr(OFS_CFG + 6'h04, (i < 2) ? 32'h11 : (i < 4) ? 32'h21 : 32'h31);
         wr(OFS_TA_CNT, 32'(c));
         pm.set_pin(4, (i % 2) == 0);
         repeat (8) @(negedge ref_clk);
         if (hit[i]) last = c;
         rchk("capture value", OFS_VAL + 6'h04, 32'(last));
         rchk("capture flag", OFS_ISTAT, hit[i] ? 32'h10 : 32'h0);
         wr(OFS_ISTAT, 32'h10);
      end
      chk("capture oe", 32'h0, 32'(cc_pin_oe[4]));
      $display("capture done");
   endtask : t_capture
   task automatic t_ext();
      wr(OFS_TCTL, 32'h0f);
      wr(OFS_TA_CNT, 32'h0010);
      pm.pulses(1'h0, 5);
      repeat (4) @(negedge ref_clk);
      rchk("external count", OFS_TA_CNT, 32'h0015);
      wr(OFS_TCTL, 32'h0e);
      wr(OFS_TA_CNT, 32'h0020);
      pm.pulses(1'h1, 3);
      rchk("overflow count", OFS_TA_CNT, 32'h0023);
      wr(OFS_TA_CNT, 32'hffff);
      pm.pulses(1'h1, 1);
      rchk("reload", OFS_TA_CNT, 32'hfff0);
      $display("count sources done");
   endtask : t_ext
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_regs();
      t_compare();
      t_irq();
      t_capture();
      t_ext();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      complete_run();
   end
endmodule : capture_compare_unit_tb_top
